// File: hw/scpu_pkg.sv
// Constants and carrier types for the strap and configuration port block
package scpu_pkg;

  // Configuration register indices
  localparam logic [7:0] IDX_UNIT_SEL = 8'h07;  // Logical unit select
  localparam logic [7:0] IDX_ID_HI    = 8'h20;  // Identity high byte
  localparam logic [7:0] IDX_ID_LO    = 8'h21;  // Identity low byte
  localparam logic [7:0] IDX_CLK_SEL  = 8'h25;  // Input clock select
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;  // Unit activate
  localparam logic [7:0] IDX_BASE_HI  = 8'h60;  // I/O base upper byte
  localparam logic [7:0] IDX_BASE_LO  = 8'h61;  // I/O base lower byte
  localparam logic [7:0] IDX_IRQ_SEL  = 8'h70;  // Interrupt line select
  localparam logic [7:0] IDX_QMODE    = 8'hf6;  // Queue mode select

  // Port pair addresses
  localparam logic [15:0] PORT_IDX_HIGH  = 16'h002e;  // Strap high, index
  localparam logic [15:0] PORT_DATA_HIGH = 16'h002f;  // Strap high, data
  localparam logic [15:0] PORT_IDX_LOW   = 16'h004e;  // Strap low, index
  localparam logic [15:0] PORT_DATA_LOW  = 16'h004f;  // Strap low, data

  // Entry keys by key straps {hi, lo}, and the lock code
  localparam logic [7:0] KEY_00    = 8'h77;
  localparam logic [7:0] KEY_01    = 8'ha0;
  localparam logic [7:0] KEY_10    = 8'h87;
  localparam logic [7:0] KEY_11    = 8'h67;
  localparam logic [7:0] LOCK_CODE = 8'haa;

  // Register values
  localparam logic [7:0] CLK_SEL_24   = 8'h00;  // 24 MHz input clock
  localparam logic [7:0] CLK_SEL_48   = 8'h01;  // 48 MHz input clock
  localparam logic [7:0] QMODE_DEEP   = 8'h03;  // 128-byte queues
  localparam logic [7:0] QMODE_SHALLOW = 8'h00; // 16-byte queues
  localparam logic [7:0] REG_ZERO     = 8'h00;
  localparam logic [7:0] UNIT_ON      = 8'h01;  // Activate value
  localparam logic [7:0] BUS_FLOAT    = 8'hff;  // Read while the mode is closed

  // Logical units and their slots
  localparam int         NUM_UNITS = 5;
  localparam logic [7:0] LUN_WDT   = 8'h08;   // Watchdog unit number
  localparam logic [2:0] SLOT_CH1  = 3'h0;
  localparam logic [2:0] SLOT_CH2  = 3'h1;
  localparam logic [2:0] SLOT_CH3  = 3'h2;
  localparam logic [2:0] SLOT_CH4  = 3'h3;
  localparam logic [2:0] SLOT_WDT  = 3'h4;

  // Strap presets
  localparam logic [7:0] BHI_CH1 = 8'h03;
  localparam logic [7:0] BHI_CH2 = 8'h02;
  localparam logic [7:0] BHI_CH3 = 8'h03;
  localparam logic [7:0] BHI_CH4 = 8'h02;
  localparam logic [7:0] BHI_WDT = 8'h04;
  localparam logic [7:0] BLO_MAIN = 8'hf8;   // Channels 1 and 2 main base
  localparam logic [7:0] BLO_ALT  = 8'he0;   // Channels 1 and 2 alt base
  localparam logic [7:0] BLO_EIGHT = 8'he8;  // Channels 3 and 4
  localparam logic [7:0] BLO_WDT  = 8'h42;
  localparam logic [7:0] IRQ_CH1 = 8'h03;
  localparam logic [7:0] IRQ_CH2 = 8'h04;
  localparam logic [7:0] IRQ_CH3 = 8'h05;
  localparam logic [7:0] IRQ_CH4 = 8'h09;
  localparam logic [7:0] IRQ_WDT = 8'h00;

  // Sampled strap levels
  typedef struct packed {
    logic chan1_main_base_strap;
    logic chan1_alt_base_strap;
    logic chan2_main_base_strap;
    logic chan2_alt_base_strap;
    logic chan3_default_strap;
    logic chan4_default_strap;
    logic watchdog_enable_strap;
    logic config_port_address_strap;
    logic unlock_key_strap_hi;
    logic unlock_key_strap_lo;
  } scpu_strap_t;

  // One host I/O cycle
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } scpu_io_req_t;

  // Per-unit configuration seen by the unit
  typedef struct packed {
    logic        active;
    logic [15:0] base;
    logic [7:0]  irq_sel;
    logic        deep_queue;
  } scpu_unit_cfg_t;

endpackage

// File: hw/scpu_key_detect.sv
// Entry key detector and configuration mode flag
`timescale 1ns/100ps
module scpu_key_detect
  import scpu_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  input  wire logic       idx_wr,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] key,
  output logic            cfg_open
);

  logic armed_q;  // First key write seen
  logic open_q;   // Configuration mode open
  logic key_hit;  // Key value written to the index port

  // Key sequence and lock code handling
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      armed_q <= 1'b0;
      open_q  <= 1'b0;
    end
    else if (clk_en && idx_wr)
    begin
      if (open_q)
      begin
        // Lock code closes the mode
        if (wdata == LOCK_CODE)
          open_q <= 1'b0;
      end
      else if (wdata == key)
      begin
        // Second consecutive key opens
        open_q  <= armed_q;
        armed_q <= !armed_q;
      end
      else
        armed_q <= 1'b0;
    end
  end

  assign cfg_open = open_q;

  // Helper for the history check below
  assign key_hit = clk_en && idx_wr && (wdata == key);

  sequence key_hit_s;
    clk_en && idx_wr && (wdata == key);
  endsequence

  // Opening only after an armed key write
  open_gate_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    $rose(open_q) |-> $past(armed_q) && $past(key_hit))
    else $error("mode opened without two key writes");

  // Armed plus key opens next cycle
  open_take_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (!open_q && armed_q) ##0 key_hit_s |=> open_q && !armed_q)
    else $error("second key write did not open");

  // Lock code closes the mode
  lock_close_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    open_q && clk_en && idx_wr && wdata == LOCK_CODE |=> !open_q)
    else $error("lock code did not close");

  // Wrong value drops the first key
  key_restart_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !open_q && armed_q && clk_en && idx_wr && wdata != key
      |=> !armed_q && !open_q)
    else $error("key detector did not restart");

endmodule

// File: hw/scpu_top.sv
// Strap sampling and keyed index/data configuration register bank
`timescale 1ns/100ps
module scpu_top
  import scpu_pkg::*;
#(
  parameter logic [7:0] ID_HI = 8'h5a,  // Arbitrary identity value
  parameter logic [7:0] ID_LO = 8'hc3   // Arbitrary identity value
)
(
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire logic                  clk_en,
  input  wire scpu_pkg::scpu_strap_t straps,
  input  wire scpu_pkg::scpu_io_req_t io_req,
  output logic [7:0]                 io_rdata,
  output logic                       io_rd_valid,
  output logic                       cfg_open,
  output logic                       clk_48m_sel,
  output scpu_pkg::scpu_unit_cfg_t [scpu_pkg::NUM_UNITS-1:0] unit_cfg
);
  import scpu_pkg::*;

  // Sampled straps and registers
  scpu_strap_t strap_q;            // Levels caught during reset
  logic [7:0]  index_q;            // Selected register index
  logic [7:0]  unit_sel_q;         // Logical unit select
  logic [7:0]  clk_sel_q;          // Input clock select
  logic [7:0]  rdata_q;            // Read answer
  logic        rd_valid_q;         // Read answer strobe
  logic [7:0]  act_q   [NUM_UNITS];  // Unit activate
  logic [7:0]  bhi_q   [NUM_UNITS];  // Base upper byte
  logic [7:0]  blo_q   [NUM_UNITS];  // Base lower byte
  logic [7:0]  irq_q   [NUM_UNITS];  // Interrupt select
  logic [7:0]  qmode_q [NUM_UNITS];  // Queue mode

  // Decode
  logic [15:0] idx_port;    // Index port address
  logic [15:0] data_port;   // Data port address
  logic [7:0]  entry_key;   // Key in force
  logic        idx_wr;      // Index port write
  logic        data_wr;     // Data port write, mode open
  logic        port_rd;     // Read of either port
  logic [2:0]  slot;        // Slot of selected unit
  logic        slot_ok;     // Selected unit exists
  logic [7:0]  reg_val;     // Value at current index

  // Presets for one slot: {activate, base hi, base lo, irq}
  function automatic logic [31:0] preset_of(input logic [2:0] s,
                                            input scpu_strap_t p);
    logic [31:0] v;
    v = {REG_ZERO, REG_ZERO, REG_ZERO, REG_ZERO};
    case (s)
      SLOT_CH1:
        if (p.chan1_main_base_strap)
          v = {UNIT_ON, BHI_CH1, BLO_MAIN, IRQ_CH1};
        else if (p.chan1_alt_base_strap)
          v = {UNIT_ON, BHI_CH1, BLO_ALT, IRQ_CH1};
      SLOT_CH2:
        if (p.chan2_main_base_strap)
          v = {UNIT_ON, BHI_CH2, BLO_MAIN, IRQ_CH2};
        else if (p.chan2_alt_base_strap)
          v = {UNIT_ON, BHI_CH2, BLO_ALT, IRQ_CH2};
      SLOT_CH3:
        if (p.chan3_default_strap)
          v = {UNIT_ON, BHI_CH3, BLO_EIGHT, IRQ_CH3};
      SLOT_CH4:
        if (p.chan4_default_strap)
          v = {UNIT_ON, BHI_CH4, BLO_EIGHT, IRQ_CH4};
      SLOT_WDT:
        if (p.watchdog_enable_strap)
          v = {UNIT_ON, BHI_WDT, BLO_WDT, IRQ_WDT};
      default:
        v = {REG_ZERO, REG_ZERO, REG_ZERO, REG_ZERO};
    endcase
    return v;
  endfunction

  // Port pair from the sampled port strap
  always_comb
  begin
    if (strap_q.config_port_address_strap)
    begin
      idx_port  = PORT_IDX_HIGH;
      data_port = PORT_DATA_HIGH;
    end
    else
    begin
      idx_port  = PORT_IDX_LOW;
      data_port = PORT_DATA_LOW;
    end
  end

  // Entry key from the sampled key straps
  always_comb
  begin
    case ({strap_q.unlock_key_strap_hi, strap_q.unlock_key_strap_lo})
      2'b00:   entry_key = KEY_00;
      2'b01:   entry_key = KEY_01;
      2'b10:   entry_key = KEY_10;
      default: entry_key = KEY_11;
    endcase
  end

  // Cycle decode
  assign idx_wr  = io_req.wr && (io_req.addr == idx_port);
  assign data_wr = io_req.wr && (io_req.addr == data_port) && cfg_open;
  assign port_rd = io_req.rd &&
                   ((io_req.addr == idx_port) || (io_req.addr == data_port));

  // Logical unit to slot
  always_comb
  begin
    slot    = unit_sel_q[2:0];
    slot_ok = (unit_sel_q <= {5'h00, SLOT_CH4});
    if (unit_sel_q == LUN_WDT)
    begin
      slot    = SLOT_WDT;
      slot_ok = 1'b1;
    end
  end

  // Mode flag and key detection
  scpu_key_detect scpu_key_detect_inst
  (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clk_en   (clk_en),
    .idx_wr   (idx_wr),
    .wdata    (io_req.wdata),
    .key      (entry_key),
    .cfg_open (cfg_open)
  );

  // Strap capture, repeated every clock edge while reset is held
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      strap_q <= straps;
  end

  // Index register, only while open
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      index_q <= REG_ZERO;
    else if (clk_en && idx_wr && cfg_open)
      index_q <= io_req.wdata;
  end

  // Global registers
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      unit_sel_q <= REG_ZERO;
      clk_sel_q  <= CLK_SEL_24;
    end
    else if (clk_en && data_wr)
    begin
      // Selected by index
      case (index_q)
        IDX_UNIT_SEL: unit_sel_q <= io_req.wdata;
        IDX_CLK_SEL:  clk_sel_q  <= io_req.wdata;
        default:      ;
      endcase
    end
  end

  // Per-unit registers, preset from straps during reset; queue mode resets to shallow
  for (genvar g = 0; g < NUM_UNITS; g++)
  begin : g_unit
    logic [31:0] pre;  // Preset bundle for this slot
    logic        hit;  // Data write aimed at this slot
    assign pre = preset_of(3'(g), straps);
    assign hit = clk_en && data_wr && slot_ok && (slot == 3'(g));

    always_ff @(posedge core_clk)
    begin
      if (!nrst)
      begin
        act_q[g]   <= pre[31:24];
        bhi_q[g]   <= pre[23:16];
        blo_q[g]   <= pre[15:8];
        irq_q[g]   <= pre[7:0];
        qmode_q[g] <= QMODE_SHALLOW;
      end
      else if (hit)
      begin
        // Software overrides presets
        case (index_q)
          IDX_ACTIVATE: act_q[g]   <= io_req.wdata;
          IDX_BASE_HI:  bhi_q[g]   <= io_req.wdata;
          IDX_BASE_LO:  blo_q[g]   <= io_req.wdata;
          IDX_IRQ_SEL:  irq_q[g]   <= io_req.wdata;
          IDX_QMODE:    qmode_q[g] <= io_req.wdata;
          default:      ;
        endcase
      end
    end

    // Unit view of its configuration
    assign unit_cfg[g].active     = (act_q[g] == UNIT_ON);
    assign unit_cfg[g].base       = {bhi_q[g], blo_q[g]};
    assign unit_cfg[g].irq_sel    = irq_q[g];
    assign unit_cfg[g].deep_queue = (qmode_q[g] == QMODE_DEEP);
  end

  // Selected 48 MHz only on value one; else 24 MHz
  assign clk_48m_sel = (clk_sel_q == CLK_SEL_48);

  // Register value at the current index
  always_comb
  begin
    reg_val = REG_ZERO;
    case (index_q)
      IDX_UNIT_SEL: reg_val = unit_sel_q;
      IDX_ID_HI:    reg_val = ID_HI;
      IDX_ID_LO:    reg_val = ID_LO;
      IDX_CLK_SEL:  reg_val = clk_sel_q;
      IDX_ACTIVATE: reg_val = slot_ok ? act_q[slot] : REG_ZERO;
      IDX_BASE_HI:  reg_val = slot_ok ? bhi_q[slot] : REG_ZERO;
      IDX_BASE_LO:  reg_val = slot_ok ? blo_q[slot] : REG_ZERO;
      IDX_IRQ_SEL:  reg_val = slot_ok ? irq_q[slot] : REG_ZERO;
      IDX_QMODE:    reg_val = slot_ok ? qmode_q[slot] : REG_ZERO;
      default:      reg_val = REG_ZERO;
    endcase
  end

  // Read answer, one cycle after the request
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      rdata_q    <= BUS_FLOAT;
      rd_valid_q <= 1'b0;
    end
    else if (clk_en)
    begin
      rd_valid_q <= port_rd;
      if (port_rd)
      begin
        if (!cfg_open)
          rdata_q <= BUS_FLOAT;
        else if (io_req.addr == data_port)
          rdata_q <= reg_val;
        else
          rdata_q <= index_q;
      end
    end
  end

  assign io_rdata    = rdata_q;
  assign io_rd_valid = rd_valid_q;

  // Checks

  sequence data_read_s;
    clk_en && cfg_open && io_req.rd && io_req.addr == data_port;
  endsequence

  sequence data_write_s(logic [7:0] v);
    clk_en && data_wr && io_req.wdata == v;
  endsequence

  // First cycle after reset holds strap presets
  preset_load_a: assert property (
    @(posedge core_clk)
    $rose(nrst) |->
      {act_q[SLOT_CH1], bhi_q[SLOT_CH1], blo_q[SLOT_CH1], irq_q[SLOT_CH1]}
        == preset_of(SLOT_CH1, strap_q) &&
      {act_q[SLOT_WDT], bhi_q[SLOT_WDT], blo_q[SLOT_WDT], irq_q[SLOT_WDT]}
        == preset_of(SLOT_WDT, strap_q))
    else $error("presets not loaded from straps");

  // Closed mode leaves registers untouched
  closed_write_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !cfg_open && io_req.wr |=>
      $stable(clk_sel_q) && $stable(unit_sel_q) && $stable(unit_cfg))
    else $error("register changed while closed");

  // Closed mode reads float
  closed_read_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    clk_en && port_rd && !cfg_open |=> io_rd_valid && io_rdata == BUS_FLOAT)
    else $error("closed read leaked contents");

  // Select clock index then write one gives 48 MHz
  clock_fast_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    index_q == IDX_CLK_SEL ##0 data_write_s(CLK_SEL_48) |=> clk_48m_sel)
    else $error("clock select one not 48 MHz");

  // Write zero gives 24 MHz
  clock_slow_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    index_q == IDX_CLK_SEL ##0 data_write_s(CLK_SEL_24) |=> !clk_48m_sel)
    else $error("clock select zero not 24 MHz");

  // Queue mode three on selected unit gives deep queues
  queue_deep_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    index_q == IDX_QMODE && slot_ok ##0 data_write_s(QMODE_DEEP)
      |=> unit_cfg[slot].deep_queue)
    else $error("queue mode three not deep");

  // Queue mode zero gives shallow queues
  queue_shallow_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    index_q == IDX_QMODE && slot_ok ##0 data_write_s(QMODE_SHALLOW)
      |=> !unit_cfg[slot].deep_queue)
    else $error("queue mode zero not shallow");

  // Activate one enables the selected unit
  unit_activate_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    index_q == IDX_ACTIVATE && slot_ok ##0 data_write_s(UNIT_ON)
      |=> unit_cfg[slot].active)
    else $error("activate did not enable unit");

  // Data read at the identity index returns it
  ident_read_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    index_q == IDX_ID_HI ##0 data_read_s
      |=> io_rd_valid && io_rdata == ID_HI)
    else $error("identity high byte wrong");

endmodule

// File: bench/scpu_host_model.sv
// Host model issuing index and data port I/O cycles
`timescale 1ns/100ps
module scpu_host_model
(
  input  wire logic             core_clk,
  input  wire logic [7:0]       io_rdata,
  input  wire logic             io_rd_valid,
  output scpu_pkg::scpu_io_req_t io_req
);
  import scpu_pkg::*;

  // Bus idle at time zero
  initial io_req = '0;

  // Release: strobes low, address and data inverted so nothing stale lingers
  task automatic release_bus();
    io_req.wr    = 1'b0;
    io_req.rd    = 1'b0;
    io_req.addr  = ~io_req.addr;
    io_req.wdata = ~io_req.wdata;
  endtask

  // One write cycle, optionally after idle cycles for a slow host
  task automatic io_write(input logic [15:0] a, input logic [7:0] d,
                          input int gap = 0);
    repeat (gap) @(negedge core_clk);
    @(negedge core_clk);
    io_req.addr  = a;
    io_req.wdata = d;
    io_req.wr    = 1'b1;
    @(negedge core_clk);
    release_bus();
  endtask

  // One read cycle; answer sampled in the cycle after the taken edge
  task automatic io_read(input logic [15:0] a, output logic [7:0] d,
                         output logic v);
    @(negedge core_clk);
    io_req.addr = a;
    io_req.rd   = 1'b1;
    @(negedge core_clk);
    d = io_rdata;
    v = io_rd_valid;
    release_bus();
  endtask
endmodule

// File: bench/tb.sv
// Testbench for the strap and configuration port block
`timescale 1ns/100ps
module tb;
  import scpu_pkg::*;

  localparam logic [7:0] TB_ID_HI = 8'h3c;  // Arbitrary identity value
  localparam logic [7:0] TB_ID_LO = 8'h96;  // Arbitrary identity value
  localparam int         TIMEOUT  = 5000;   // Cycle ceiling for the run

  logic                           core_clk;
  logic                           nrst;
  logic                           clk_en;
  scpu_strap_t                    straps;
  scpu_io_req_t                   io_req;
  logic [7:0]                     io_rdata;
  logic                           io_rd_valid;
  logic                           cfg_open;
  logic                           clk_48m_sel;
  scpu_unit_cfg_t [NUM_UNITS-1:0] unit_cfg;
  int                             n_errors;
  int                             cmp_count;
  int                             cyc;
  logic [15:0]                    ip;  // Index port in use
  logic [15:0]                    dp;  // Data port in use
  logic [7:0]                     keys [4] = '{8'h77, 8'ha0, 8'h87, 8'h67};
  scpu_strap_t                    s;

  // Device under test
  scpu_top #(.ID_HI(TB_ID_HI), .ID_LO(TB_ID_LO)) scpu_top_inst (
    .core_clk    (core_clk),
    .nrst        (nrst),
    .clk_en      (clk_en),
    .straps      (straps),
    .io_req      (io_req),
    .io_rdata    (io_rdata),
    .io_rd_valid (io_rd_valid),
    .cfg_open    (cfg_open),
    .clk_48m_sel (clk_48m_sel),
    .unit_cfg    (unit_cfg)
  );

  // Bus host
  scpu_host_model scpu_host_model_inst (
    .core_clk    (core_clk),
    .io_rdata    (io_rdata),
    .io_rd_valid (io_rd_valid),
    .io_req      (io_req)
  );

  // Clock, 40 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Hang guard
  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    if (cyc == TIMEOUT)
    begin
      n_errors++;
      $display("[ERR] %0t timeout", $time);
      give_verdict();
    end
  end

  // Counts and verdict, then end of run
  task automatic give_verdict();
    $display("Mismatches %0d, comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp)
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    if (got !== exp)
      n_errors++;
  endtask

  // Port cycles
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    scpu_host_model_inst.io_write(a, d);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e,
                    input string what);
    logic [7:0] d;
    logic       v;
    scpu_host_model_inst.io_read(a, d, v);
    chk(32'(v), 32'h1, "read valid");
    chk(32'(d), 32'(e), what);
  endtask

  // Select an index, then write its contents
  task automatic wreg(input logic [7:0] i, input logic [7:0] v);
    wr(ip, i);
    wr(dp, v);
  endtask

  // Reset with given straps held for 4 cycles; port pair follows strap
  task automatic do_reset(input scpu_strap_t st);
    @(negedge core_clk);
    nrst   = 1'b0;
    straps = st;
    repeat (4) @(negedge core_clk);
    nrst = 1'b1;
    ip   = st.config_port_address_strap ? 16'h002e : 16'h004e;
    dp   = ip + 16'h0001;
  endtask

  // Expected preset of one unit slot
  function automatic scpu_unit_cfg_t preset(input int k, input scpu_strap_t t);
    logic [7:0]     irqs [5] = '{8'h03, 8'h04, 8'h05, 8'h09, 8'h00};
    logic [15:0]    b;
    logic           on;
    scpu_unit_cfg_t c;
    on = (k == 0) ? (t.chan1_main_base_strap | t.chan1_alt_base_strap) :
         (k == 1) ? (t.chan2_main_base_strap | t.chan2_alt_base_strap) :
         (k == 2) ? t.chan3_default_strap :
         (k == 3) ? t.chan4_default_strap : t.watchdog_enable_strap;
    b = (k == 0) ? (t.chan1_main_base_strap ? 16'h03f8 : 16'h03e0) :
        (k == 1) ? (t.chan2_main_base_strap ? 16'h02f8 : 16'h02e0) :
        (k == 2) ? 16'h03e8 : (k == 3) ? 16'h02e8 : 16'h0442;
    c.active     = on;
    c.base       = on ? b : 16'h0000;
    c.irq_sel    = on ? irqs[k] : 8'h00;
    c.deep_queue = 1'b0;
    return c;
  endfunction

  // All five slots against their presets
  task automatic check_presets(input scpu_strap_t t);
    for (int k = 0; k < NUM_UNITS; k++)
      chk(32'(unit_cfg[k]), 32'(preset(k, t)), "preset");
  endtask

  // Main sequence
  initial
  begin
    nrst      = 1'b0;
    clk_en    = 1'b1;
    straps    = '1;
    n_errors  = 0;
    cmp_count = 0;
    cyc       = 0;
    ip        = 16'h002e;
    dp        = 16'h002f;
    // Undriven port strap is presented high
    do_reset('1);
    check_presets('1);
    // Closed mode ignores data writes and reads float
    wreg(IDX_ACTIVATE, 8'h00);
    chk(32'(unit_cfg[0]), 32'(preset(0, '1)), "closed wr");
    rd(dp, 8'hff, "closed rd");
    // Foreign value between keys restarts detection
    wr(ip, 8'h67);
    wr(ip, 8'h55);
    wr(ip, 8'h67);
    chk(32'(cfg_open), 32'h0, "restart");
    scpu_host_model_inst.io_write(ip, 8'h67, 3);
    chk(32'(cfg_open), 32'h1, "open");
    // Identity bytes, read only
    wr(ip, 8'h20);
    rd(dp, TB_ID_HI, "id hi");
    wreg(8'h21, 8'h00);
    rd(dp, TB_ID_LO, "id lo");
    rd(ip, 8'h21, "index");
    // Input clock select
    wreg(8'h25, 8'h01);
    chk(32'(clk_48m_sel), 32'h1, "clk 48");
    rd(dp, 8'h01, "clk rd");
    wreg(8'h25, 8'h00);
    chk(32'(clk_48m_sel), 32'h0, "clk 24");
    // Second channel queue mode, activate and base
    wreg(8'h07, 8'h01);
    wreg(8'hf6, 8'h03);
    chk(32'(unit_cfg[1].deep_queue), 32'h1, "deep");
    chk(32'(unit_cfg[0].deep_queue), 32'h0, "other");
    wreg(8'hf6, 8'h00);
    chk(32'(unit_cfg[1].deep_queue), 32'h0, "shallow");
    wreg(8'h30, 8'h00);
    chk(32'(unit_cfg[1].active), 32'h0, "off");
    wreg(8'h30, 8'h01);
    chk(32'(unit_cfg[1].active), 32'h1, "on");
    wreg(8'h60, 8'h12);
    wreg(8'h61, 8'h34);
    wreg(8'h70, 8'h07);
    chk(32'(unit_cfg[1].base), 32'h1234, "base");
    chk(32'(unit_cfg[1].irq_sel), 32'h07, "irq");
    // Watchdog unit, then a unit number that does not exist
    wreg(8'h07, 8'h08);
    wr(ip, 8'h61);
    rd(dp, 8'h42, "wdt base lo");
    wreg(8'h07, 8'h05);
    wreg(8'h30, 8'h01);
    rd(dp, 8'h00, "absent unit");
    wreg(8'h07, 8'h01);
    // Frozen clock enable ignores cycles
    clk_en = 1'b0;
    wreg(8'h70, 8'h0b);
    clk_en = 1'b1;
    chk(32'(unit_cfg[1].irq_sel), 32'h07, "clk_en");
    // Lock code closes access
    wr(ip, 8'haa);
    chk(32'(cfg_open), 32'h0, "lock");
    wr(dp, 8'h0f);
    chk(32'(unit_cfg[1].irq_sel), 32'h07, "locked wr");
    rd(dp, 8'hff, "locked rd");
    // Strap patterns: presets, port pair and key
    for (int i = 0; i < 4; i++)
    begin
      s = '0;
      s.chan1_main_base_strap     = i[1];
      s.chan1_alt_base_strap      = i[0];
      s.chan2_main_base_strap     = i[0];
      s.chan2_alt_base_strap      = i[1];
      s.chan3_default_strap       = i[1];
      s.chan4_default_strap       = i[0];
      s.watchdog_enable_strap     = i[1];
      s.config_port_address_strap = i[0];
      s.unlock_key_strap_hi       = i[1];
      s.unlock_key_strap_lo       = i[0];
      do_reset(s);
      check_presets(s);
      wr(ip ^ 16'h0060, keys[i]);
      wr(ip ^ 16'h0060, keys[i]);
      chk(32'(cfg_open), 32'h0, "wrong port");
      wr(ip, keys[i^1]);
      wr(ip, keys[i^1]);
      chk(32'(cfg_open), 32'h0, "wrong key");
      wr(ip, keys[i]);
      wr(ip, keys[i]);
      chk(32'(cfg_open), 32'h1, "key");
      wr(ip, 8'haa);
    end
    give_verdict();
  end
endmodule
